//--- hw/xor_skip_exec.sv
// Execution unit for table write, test-skip-zero and the two xor forms.
//
// Contract
// - Table write is one word, two cycles; post forms store at old address.
// - Pre-increment advances the pointer first, then stores at the new address.
// - Test-skip-zero reads the register; on zero the next word becomes a no-op.
// - A skipped two-word instruction costs two no-op cycles, three in all.
// - Access bit 0 selects the fixed access bank, 1 the bank select value.
// - Xor-literal xors the working register with the literal in one cycle.
// - Xor-register result goes to working register if d is 0, else back.
// - Both xors set negative and zero; test and table write keep flags.
// - The low three pointer bits pick one of eight holding latches.
// - The pointer is 21 bits, byte addressed; bit 0 is the low bit of the latch index.
`timescale 1ns/1ns
`default_nettype none

module xor_skip_exec #(
   parameter int PTR_W = xor_skip_pkg::PTR_W
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Instruction fetch path.
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_two_word,
   output logic             instr_ready,
   // Data register file.
   output logic [11:0]      data_addr,
   input  wire logic [7:0]  data_rd_data,
   output logic             data_wr_en,
   output logic [7:0]       data_wr_data
);

   initial begin
      if (PTR_W < xor_skip_pkg::HOLD_IDX_W + 1) begin
         $error("table pointer too narrow for the holding latch index");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [3:0]                   phase;
   xor_skip_pkg::core_state_t    state;
   logic [15:0]                  ir;
   logic                         ir_valid;
   logic [7:0]                   operand;
   logic [7:0]                   result;
   logic [7:0]                   work;
   logic [3:0]                   bank;
   logic [1:0]                   flags;
   logic [PTR_W-1:0]             ptr;
   logic [7:0]                   latch;
   logic                         skip_took;
   logic                         skip_two;
   logic [63:0]                  hold_flat;
   logic                         hold_we;
   logic [2:0]                   chk_idx;
   logic                         taken;
   logic                         exec;
   logic                         do_tblw;
   logic                         do_tst;
   logic                         do_xlw;
   logic                         do_xwf;
   logic [1:0]                   tw_mode;
   logic [7:0]                   rd_mux;
   logic                         mapped;
   logic                         apb_wr;
   logic                         hold_hit;
   logic [11:0]                  next_addr;

   qphase_gen u_phase (
      .pclk    (pclk),
      .presetn (presetn),
      .phase   (phase)
   );

   holding_latches u_hold (
      .pclk      (pclk),
      .presetn   (presetn),
      .wr_en     (hold_we),
      .wr_idx    (ptr[xor_skip_pkg::HOLD_IDX_W-1:0]),
      .wr_data   (latch),
      .hold_flat (hold_flat)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decode of the held instruction.
   assign exec    = state == xor_skip_pkg::ST_EXEC;
   assign do_tblw = ir_valid && ir[15:2] == xor_skip_pkg::TBLW_TOP;
   assign do_tst  = ir_valid && ir[15:9] == xor_skip_pkg::TST_TOP;
   assign do_xlw  = ir_valid && ir[15:8] == xor_skip_pkg::XLW_TOP;
   assign do_xwf  = ir_valid && ir[15:10] == xor_skip_pkg::XWF_TOP;
   assign tw_mode = ir[xor_skip_pkg::FLD_MODE_W-1:0];

   // A word is taken in the first phase of every cycle but a table write's.
   assign instr_ready = phase[0] && state != xor_skip_pkg::ST_TBLW;
   assign taken       = instr_ready && instr_valid;

   // Operand address, banked or through the access bank.
   always_comb begin
      if (instr_word[xor_skip_pkg::FLD_A]) begin
         next_addr = {bank, instr_word[7:0]};
      end else if (instr_word[xor_skip_pkg::FLD_ACC_HI]) begin
         next_addr = {xor_skip_pkg::ACC_HIGH_BANK, instr_word[7:0]};
      end else begin
         next_addr = {xor_skip_pkg::ACC_LOW_BANK, instr_word[7:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir        <= '0;
         ir_valid  <= 1'b0;
         data_addr <= '0;
      end else if (phase[0]) begin
         if (exec) begin
            ir_valid <= instr_valid;
            if (instr_valid) begin
               ir        <= instr_word;
               data_addr <= next_addr;
            end
         end else if (state != xor_skip_pkg::ST_TBLW) begin
            ir_valid <= 1'b0;
         end
      end
   end

   // Read in the second phase, process in the third.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operand <= xor_skip_pkg::RST_BYTE;
         result  <= xor_skip_pkg::RST_BYTE;
      end else begin
         if (phase[1]) begin
            operand <= data_rd_data;
         end
         if (phase[2]) begin
            result <= work ^ (do_xlw ? ir[7:0] : operand);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cycle sequencer; state changes happen at the fourth phase, the skip flags are caught at the first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_took <= 1'b0;
         skip_two  <= 1'b0;
      end else if (phase[0]) begin
         skip_took <= taken;
         skip_two  <= taken && instr_two_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= xor_skip_pkg::ST_EXEC;
      end else if (phase[3]) begin
         case (state)
            xor_skip_pkg::ST_EXEC: begin
               if (do_tblw) begin
                  state <= xor_skip_pkg::ST_TBLW;
               end else if (do_tst && operand == xor_skip_pkg::RST_BYTE) begin
                  state <= xor_skip_pkg::ST_SKIP1;
               end else begin
                  state <= xor_skip_pkg::ST_EXEC;
               end
            end
            xor_skip_pkg::ST_TBLW: begin
               state <= xor_skip_pkg::ST_EXEC;
            end
            xor_skip_pkg::ST_SKIP1: begin
               if (skip_took && skip_two) begin
                  state <= xor_skip_pkg::ST_SKIP2;
               end else if (skip_took) begin
                  state <= xor_skip_pkg::ST_EXEC;
               end
            end
            xor_skip_pkg::ST_SKIP2: begin
               if (skip_took) begin
                  state <= xor_skip_pkg::ST_EXEC;
               end
            end
            default: begin
               state <= xor_skip_pkg::ST_EXEC;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file; a core update in the same cycle wins over software.
   assign apb_wr   = psel && penable && pwrite;
   assign hold_hit = (paddr & xor_skip_pkg::HOLD_MASK) == xor_skip_pkg::REG_HOLD;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         work  <= xor_skip_pkg::RST_BYTE;
         flags <= '0;
      end else begin
         if (apb_wr && paddr == xor_skip_pkg::REG_WORK) begin
            work <= pwdata[7:0];
         end
         if (apb_wr && paddr == xor_skip_pkg::REG_FLAGS) begin
            flags <= pwdata[xor_skip_pkg::FLAG_W-1:0];
         end
         if (phase[3] && exec && (do_xlw || do_xwf)) begin
            flags[xor_skip_pkg::FLAG_Z] <= result == xor_skip_pkg::RST_BYTE;
            flags[xor_skip_pkg::FLAG_N] <= result[7];
            if (do_xlw || !ir[xor_skip_pkg::FLD_D]) begin
               work <= result;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_wr_en   <= 1'b0;
         data_wr_data <= xor_skip_pkg::RST_BYTE;
      end else begin
         data_wr_en <= phase[3] && exec && do_xwf && ir[xor_skip_pkg::FLD_D];
         if (phase[3]) begin
            data_wr_data <= result;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank  <= '0;
         latch <= xor_skip_pkg::RST_BYTE;
      end else if (apb_wr) begin
         if (paddr == xor_skip_pkg::REG_BANK) begin
            bank <= pwdata[xor_skip_pkg::BANK_W-1:0];
         end
         if (paddr == xor_skip_pkg::REG_LATCH) begin
            latch <= pwdata[7:0];
         end
      end
   end

   // Table pointer; pre-increment moves at the end of the first cycle.
   assign hold_we = phase[3] && state == xor_skip_pkg::ST_TBLW;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr <= '0;
      end else begin
         if (apb_wr && paddr == xor_skip_pkg::REG_PTR) begin
            ptr <= pwdata[PTR_W-1:0];
         end
         if (phase[3] && exec && do_tblw && tw_mode == xor_skip_pkg::TW_PRE_INC) begin
            ptr <= ptr + PTR_W'(1);
         end
         if (hold_we && tw_mode == xor_skip_pkg::TW_POST_INC) begin
            ptr <= ptr + PTR_W'(1);
         end
         if (hold_we && tw_mode == xor_skip_pkg::TW_POST_DEC) begin
            ptr <= ptr - PTR_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB read path; data is sampled in the setup cycle.
   always_comb begin
      rd_mux = '0;
      mapped = 1'b1;
      if (hold_hit) begin
         rd_mux = hold_flat[paddr[xor_skip_pkg::HOLD_LSB +: 3]*8 +: 8];
         mapped = !pwrite;
      end else begin
         case (paddr)
            xor_skip_pkg::REG_WORK:  rd_mux = work;
            xor_skip_pkg::REG_BANK:  rd_mux = {4'h0, bank};
            xor_skip_pkg::REG_FLAGS: rd_mux = {6'h00, flags};
            xor_skip_pkg::REG_LATCH: rd_mux = latch;
            xor_skip_pkg::REG_CORE: begin
               rd_mux = {3'h0, state, ir_valid};
               mapped = !pwrite;
            end
            xor_skip_pkg::REG_PTR:   rd_mux = '0;
            default:                 mapped = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         if (paddr == xor_skip_pkg::REG_PTR) begin
            prdata <= 32'(ptr);
         end else begin
            prdata <= {24'h000000, rd_mux};
         end
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_idx <= '0;
      end else begin
         chk_idx <= ptr[2:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_xor_lit_work: assert property (
      phase[2] && exec && do_xlw |=> ##1 work == ($past(work, 2) ^ $past(ir, 2) & 16'h00FF)
   ) else $error("xor literal result wrong");

   a_xor_reg_back: assert property (
      phase[2] && exec && do_xwf && ir[9] |-> ##2 data_wr_en &&
      data_wr_data == ($past(work, 2) ^ $past(operand, 2))
   ) else $error("xor register write back wrong");

   a_xor_reg_work: assert property (
      phase[2] && exec && do_xwf && !ir[9] |-> ##2 !data_wr_en &&
      work == ($past(work, 2) ^ $past(operand, 2))
   ) else $error("xor register to working register wrong");

   a_xor_flag_set: assert property (
      phase[3] && exec && (do_xlw || do_xwf) |=> flags[0] == ($past(result) == 8'h00)
      && flags[1] == $past(result[7])
   ) else $error("xor flags wrong");

   a_flag_keep: assert property (
      phase[3] && ((exec && (do_tst || do_tblw)) || state == xor_skip_pkg::ST_TBLW)
      && !(apb_wr && paddr == xor_skip_pkg::REG_FLAGS) |=> $stable(flags)
   ) else $error("flags changed by test or table write");

   a_skip_zero: assert property (
      phase[3] && exec && do_tst && operand == 8'h00 |=>
      state == xor_skip_pkg::ST_SKIP1 ##1 !ir_valid
   ) else $error("zero test did not skip");

   a_skip_none: assert property (
      phase[3] && exec && do_tst && operand != 8'h00 |=> exec
   ) else $error("nonzero test skipped");

   a_skip_two_word: assert property (
      phase[3] && state == xor_skip_pkg::ST_SKIP1 && skip_took && skip_two
      |=> state == xor_skip_pkg::ST_SKIP2 [*4]
   ) else $error("two word skip too short");

   a_tblw_two_cyc: assert property (
      phase[3] && exec && do_tblw |=> state == xor_skip_pkg::ST_TBLW [*4] ##1 exec
   ) else $error("table write not two cycles");

   a_tblw_post: assert property (
      hold_we && tw_mode == xor_skip_pkg::TW_POST_INC |=> ptr == $past(ptr) + 21'h000001
      && hold_flat[chk_idx*8 +: 8] == $past(latch)
   ) else $error("post increment table write wrong");

   a_tblw_pre: assert property (
      phase[3] && exec && do_tblw && tw_mode == xor_skip_pkg::TW_PRE_INC
      |=> ptr == $past(ptr) + 21'h000001 ##4 hold_flat[chk_idx*8 +: 8] == $past(latch)
   ) else $error("pre increment table write wrong");

   a_bank_access: assert property (
      taken && exec && !instr_word[8] |=> data_addr[11:8] ==
      ($past(instr_word[7]) ? 4'hF : 4'h0)
   ) else $error("access bank not selected");

   c_skip_two: cover property (
      state == xor_skip_pkg::ST_SKIP2 && phase[3] && skip_took);
   c_tblw_pre: cover property (hold_we && tw_mode == xor_skip_pkg::TW_PRE_INC);
   c_xwf_back: cover property (data_wr_en);
   c_skip_one: cover property (
      state == xor_skip_pkg::ST_SKIP1 && phase[3] && skip_took && !skip_two);

endmodule

`default_nettype wire

//--- hw/xor_skip_pkg.sv
// Constants and types shared by the table-write, skip and xor execution unit.
`default_nettype none

package xor_skip_pkg;

   // Widths of the core datapath.
   localparam int DATA_W     = 8;
   localparam int INSTR_W    = 16;
   localparam int DADDR_W    = 12;
   localparam int BANK_W     = 4;
   localparam int PTR_W      = 21;
   localparam int HOLD_N     = 8;
   localparam int HOLD_IDX_W = 3;
   localparam int Q_PHASES   = 4;
   localparam int APB_AW     = 8;
   localparam int APB_DW     = 32;

   // Opcode fields, compared against the top bits of the instruction word.
   localparam logic [13:0] TBLW_TOP = 14'h0003;
   localparam logic [6:0]  TST_TOP  = 7'h33;
   localparam logic [7:0]  XLW_TOP  = 8'h0A;
   localparam logic [5:0]  XWF_TOP  = 6'h06;

   // Field positions inside the instruction word.
   localparam int FLD_D      = 9;
   localparam int FLD_A      = 8;
   localparam int FLD_ACC_HI = 7;
   localparam int FLD_MODE_W = 2;

   // Table write pointer modes.
   localparam logic [1:0] TW_KEEP = 2'h0;
   localparam logic [1:0] TW_POST_INC = 2'h1;
   localparam logic [1:0] TW_POST_DEC = 2'h2;
   localparam logic [1:0] TW_PRE_INC  = 2'h3;

   // Fixed access bank halves.
   localparam logic [BANK_W-1:0] ACC_LOW_BANK  = 4'h0;
   localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hF;

   // Status flag positions.
   localparam int FLAG_Z = 0;
   localparam int FLAG_N = 1;
   localparam int FLAG_W = 2;

   // Register map, byte addresses.
   localparam logic [APB_AW-1:0] REG_WORK  = 8'h00;
   localparam logic [APB_AW-1:0] REG_BANK  = 8'h04;
   localparam logic [APB_AW-1:0] REG_FLAGS = 8'h08;
   localparam logic [APB_AW-1:0] REG_PTR   = 8'h0C;
   localparam logic [APB_AW-1:0] REG_LATCH = 8'h10;
   localparam logic [APB_AW-1:0] REG_CORE  = 8'h14;
   localparam logic [APB_AW-1:0] REG_HOLD  = 8'h20;
   localparam logic [APB_AW-1:0] HOLD_MASK = 8'hE3;
   localparam int                HOLD_LSB  = 2;

   // Reset values.
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic [3:0]        RST_PHASE = 4'h1;

   typedef enum logic [3:0] {
      ST_EXEC  = 4'h1,
      ST_TBLW  = 4'h2,
      ST_SKIP1 = 4'h4,
      ST_SKIP2 = 4'h8
   } core_state_t;

endpackage

`default_nettype wire

//--- hw/qphase_gen.sv
// Rotating one-hot generator of the four internal phases of a cycle.
`timescale 1ns/1ns
`default_nettype none

module qphase_gen (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Phase enables, bit 0 is the first phase.
   output logic [3:0]      phase
);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= xor_skip_pkg::RST_PHASE;
      end else begin
         phase <= {phase[2:0], phase[3]};
      end
   end

endmodule

`default_nettype wire

//--- hw/holding_latches.sv
// Bank of byte-wide holding latches that collect program data.
`timescale 1ns/1ns
`default_nettype none

module holding_latches #(
   parameter int N     = xor_skip_pkg::HOLD_N,
   parameter int IDX_W = xor_skip_pkg::HOLD_IDX_W
) (
   // Clock and reset.
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Write port.
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [7:0]       wr_data,
   // All latches, entry i at bits 8*i and up.
   output logic [N*8-1:0]        hold_flat
);

   initial begin
      if (N != (1 << IDX_W)) begin
         $error("holding latch count must be two to the index width");
      end
   end

   // Each entry is its own variable so that every process owns what it writes.
   logic [7:0] ent [N];

   for (genvar i = 0; i < N; i++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ent[i] <= xor_skip_pkg::RST_BYTE;
         end else if (wr_en && wr_idx == IDX_W'(i)) begin
            ent[i] <= wr_data;
         end
      end
      assign hold_flat[i*8 +: 8] = ent[i];
   end

endmodule

`default_nettype wire

//--- verification/fetch_regfile_model.sv
// Fetch path and banked register file model facing the execution unit.
`timescale 1ns/1ns
`default_nettype none

module fetch_regfile_model (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Bench control.
   input  wire logic [7:0]  prog_len,
   input  wire logic        stall,
   // Fetch path.
   output logic             instr_valid,
   output logic [15:0]      instr_word,
   output logic             instr_two_word,
   input  wire logic        instr_ready,
   // Register file.
   input  wire logic [11:0] data_addr,
   output logic [7:0]       data_rd_data,
   input  wire logic        data_wr_en,
   input  wire logic [7:0]  data_wr_data
);
   logic [15:0] prog [256];
   logic        two [256];
   logic [7:0]  mem [4096];
   logic [7:0]  pc;
   logic [7:0]  pc_nx;

   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'h00;
      end
      for (int i = 0; i < 256; i++) begin
         prog[i] = 16'h0000;
         two[i] = 1'b0;
      end
   end

   assign pc_nx = pc + {7'h00, instr_valid & instr_ready};
   // An offered word is held until taken; a stall only delays the next one.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= 8'h00;
         instr_valid <= 1'b0;
      end else begin
         pc <= pc_nx;
         instr_valid <= (instr_valid & ~instr_ready) |
                        ((pc_nx < prog_len) & ~stall);
      end
   end

   // A word not on offer shows the inverse so it is never mistaken.
   assign instr_word = instr_valid ? prog[pc] : ~prog[pc];
   assign instr_two_word = instr_valid ? two[pc] : ~two[pc];
   assign data_rd_data = mem[data_addr];

   always @(posedge pclk) begin
      if (data_wr_en) begin
         mem[data_addr] <= data_wr_data;
      end
   end
endmodule

`default_nettype wire

//--- verification/table_write_test_skip_xor_exec_tb.sv
// Self-checking bench for the table-write, skip and xor execution unit.
`timescale 1ns/1ns
`default_nettype none

module table_write_test_skip_xor_exec_tb;
   localparam logic [7:0] A_W = xor_skip_pkg::REG_WORK;
   localparam logic [7:0] A_F = xor_skip_pkg::REG_FLAGS;
   localparam logic [7:0] A_P = xor_skip_pkg::REG_PTR;
   localparam logic [7:0] A_L = xor_skip_pkg::REG_LATCH;
   localparam logic [7:0] A_H = xor_skip_pkg::REG_HOLD;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        instr_valid;
   logic [15:0] instr_word;
   logic        instr_two_word;
   logic        instr_ready;
   logic [11:0] data_addr;
   logic [7:0]  data_rd_data;
   logic        data_wr_en;
   logic [7:0]  data_wr_data;
   logic [7:0]  prog_len = 8'h00;
   logic        stall = 1'b0;
   logic        rnd = 1'b0;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          seed = 32'hE64BF7AA;
   int          cyc = 0;
   int          nxt = 0;
   int          take_t[$];
   logic [64:0] rq[$];
   logic [19:0] wq[$];
   logic [64:0] rn;
   logic [19:0] wn;
   logic [7:0]  hold_s[8];

   xor_skip_exec u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word,
      .instr_two_word, .instr_ready, .data_addr, .data_rd_data, .data_wr_en,
      .data_wr_data);
   fetch_regfile_model u_far (.pclk, .presetn, .prog_len, .stall,
      .instr_valid, .instr_word, .instr_two_word, .instr_ready, .data_addr,
      .data_rd_data, .data_wr_en, .data_wr_data);

   initial forever #10 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic [7:0] a, input logic w, logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                     input logic err);
      rq.push_back({err, m, e});
      apb(a, 1'b0, 32'h00000000);
   endtask

   task automatic put(input logic [15:0] w, input logic tw);
      u_far.prog[nxt] = w;
      u_far.two[nxt] = tw;
      nxt++;
   endtask

   task automatic go;
      int i;
      prog_len <= nxt[7:0];
      for (i = 0; i < 400 && u_far.pc != nxt[7:0]; i++) @(posedge pclk);
      if (i == 400) begin
         n_mismatch++;
         $display("wrong value at %0t: program did not drain", $time);
      end
      repeat (12) @(posedge pclk);
   endtask

   function automatic logic [31:0] fl(input logic [7:0] r);
      return {30'h0, r[7], r == 8'h00};
   endfunction

   always @(posedge pclk) begin
      stall <= rnd && ($random(seed) % 2 != 0);
      cyc++;
      if (presetn && instr_ready && instr_valid) begin
         take_t.push_back(cyc);
      end
      if (psel && penable && pready && !pwrite) begin
         rn = rq.pop_front();
         check(prdata & rn[63:32], rn[31:0], "read");
         check({31'h0, pslverr}, {31'h0, rn[64]}, "error");
      end
      if (data_wr_en === 1'b1) begin
         wn = (wq.size() > 0) ? wq.pop_front() : 20'hFFFFF;
         check({12'h0, data_addr, data_wr_data}, {12'h0, wn}, "write");
      end
   end

   initial begin
      logic [7:0] w, k, v, r, f;
      logic [20:0] p, q;
      logic [11:0] ad;
      logic d, a;
      int m, j, t;
      for (j = 0; j < 8; j++) hold_s[j] = 8'h00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_W, 32'h0, 32'hFF, 1'b0);
      rd(A_P, 32'h0, 32'h1FFFFF, 1'b0);
      rd(8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(xor_skip_pkg::REG_BANK, 1'b1, 32'h5);
      // Literal xor under random fetch stalls; the last one gives zero.
      w = 8'h00;
      rnd <= 1'b1;
      for (j = 0; j < 6; j++) begin
         k = (j == 5) ? w : 8'($random(seed));
         put({8'h0A, k}, 1'b0);
         go();
         w = w ^ k;
         rd(A_W, {24'h0, w}, 32'hFF, 1'b0);
         rd(A_F, fl(w), 32'h3, 1'b0);
      end
      rnd <= 1'b0;
      for (j = 0; j < 6; j++) begin
         v = 8'($random(seed));
         w = 8'($random(seed));
         d = j > 2;
         a = j % 3 == 2;
         f = (j % 3 == 1) ? 8'h90 : 8'h40;
         ad = a ? {4'h5, f} : {f[7] ? 4'hF : 4'h0, f};
         u_far.mem[ad] = v;
         apb(A_W, 1'b1, {24'h0, w});
         put({6'h06, d, a, f}, 1'b0);
         r = w ^ v;
         if (d) wq.push_back({ad, r});
         go();
         rd(A_W, {24'h0, d ? w : r}, 32'hFF, 1'b0);
         rd(A_F, fl(r), 32'h3, 1'b0);
      end
      for (j = 0; j < 3; j++) begin
         u_far.mem[12'h040] = (j == 0) ? 8'h01 : 8'h00;
         apb(A_W, 1'b1, 32'h0F);
         apb(A_F, 1'b1, 32'h2);
         put({7'h33, 1'b0, 8'h40}, 1'b0);
         put({8'h0A, 8'hF0}, j == 2);
         put({8'h0A, 8'h0F}, 1'b0);
         go();
         w = (j == 0) ? 8'hF0 : (j == 1) ? 8'h00 : 8'h0F;
         rd(A_W, {24'h0, w}, 32'hFF, 1'b0);
         rd(A_F, (j == 2) ? 32'h2 : fl(w), 32'h3, 1'b0);
      end
      apb(A_F, 1'b1, 32'h1);
      for (m = 0; m < 4; m++) begin
         p = (m == 1) ? 21'h1FFFFF : 21'($random(seed));
         k = 8'($random(seed));
         apb(A_P, 1'b1, {11'h0, p});
         apb(A_L, 1'b1, {24'h0, k});
         t = nxt;
         put({14'h0003, m[1:0]}, 1'b0);
         put(16'hFFFF, 1'b0);
         go();
         q = (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
         hold_s[(m == 3) ? q[2:0] : p[2:0]] = k;
         check(32'(take_t[t + 1] - take_t[t]), 32'h8, "cycles");
         rd(A_P, {11'h0, q}, 32'h1FFFFF, 1'b0);
         for (j = 0; j < 8; j++) begin
            rd(A_H + 8'(4 * j), {24'h0, hold_s[j]}, 32'hFF, 1'b0);
         end
         rd(A_F, 32'h1, 32'h3, 1'b0);
      end
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      end_sim();
   end
endmodule

`default_nettype wire
